/* mode_ctrl_consts.vh */
`ifndef MODE_CTRL_CONSTS_VH
`define MODE_CTRL_CONSTS_VH
// ==========================================================
// register offsets within the memory window
`define ADDR_W 13
`define OFS_DEV_SELECT 13'h100A
`define OFS_MODE_CTRL 13'h100C
`define OFS_DEV_CONFIG 13'h100E
`define OFS_MODE_CONFIRM 13'h1072
// boot block sections 0 and 3 of the 8KB window
`define SEC_BOOT_LO 2'h0
`define SEC_BOOT_HI 2'h3
// ==========================================================
// field positions
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_EN_BIT 2
`define BOOT_FLAG_BIT 3
`define RST_FLAG_BIT 4
`define MAX_IDX_LSB 4
`define MAX_IDX_MSB 5
`define IF_CFG_BIT 7
`define IO_SUPPLY_BIT 0
// ==========================================================
// modes and reset values
`define MODE_RESET 2'h0
`define MODE_NORMAL 2'h1
`define MODE_DPD 2'h2
`define RST_SELECT 2'h0
`define RST_MAX_IDX 2'h0
`endif

/* mode_control_cascade_config.v */
`include "mode_ctrl_consts.vh"
module mode_control_cascade_config (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // host bus, one-cycle strobes
   input wire [12:0] bus_addr,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_wdata,
   output reg [7:0] bus_rdata_ff,
   output reg bus_rvalid_ff,
   // reset cause events from pins and detectors
   input wire external_reset_input_n,
   input wire boot_detect_trig,
   input wire voltage_detect_trig,
   // straps
   input wire [1:0] cascade_id_strap,
   input wire io_supply_high,
   input wire if_cfg_strap,
   // status out
   output reg [1:0] op_mode_ff,
   output reg chip_selected_ff,
   output reg boot_block_map_en_ff
);

// ==========================================================
// synchronisers for pin inputs
// only the second flop of each pair is ever read by logic
reg [1:0] s1_ff;
reg [1:0] s2_ff;
reg [1:0] s3_ff;
reg [1:0] id1_ff;
reg [1:0] id2_ff;
reg s4a_ff;
reg s4b_ff;
reg s5a_ff;
reg s5b_ff;

// external reset pin; inverted so that high means asserted
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s1_ff <= 2'h0;
   end else begin
      s1_ff <= {s1_ff[0], ~external_reset_input_n};
   end
end

// boot detector trigger
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s2_ff <= 2'h0;
   end else begin
      s2_ff <= {s2_ff[0], boot_detect_trig};
   end
end

// internal voltage detector trigger
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s3_ff <= 2'h0;
   end else begin
      s3_ff <= {s3_ff[0], voltage_detect_trig};
   end
end

// cascade id straps; static pins, so a skew between bits settles
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      id1_ff <= 2'h0;
      id2_ff <= 2'h0;
   end else begin
      id1_ff <= cascade_id_strap;
      id2_ff <= id1_ff;
   end
end

// io supply level
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s4a_ff <= 1'b0;
      s4b_ff <= 1'b0;
   end else begin
      s4a_ff <= io_supply_high;
      s4b_ff <= s4a_ff;
   end
end

// interface strap
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      s5a_ff <= 1'b0;
      s5b_ff <= 1'b0;
   end else begin
      s5a_ff <= if_cfg_strap;
      s5b_ff <= s5a_ff;
   end
end

wire ext_rst = s1_ff[1];
wire boot_trig = s2_ff[1];
wire volt_trig = s3_ff[1];
wire [1:0] strap_id = id2_ff;

// ==========================================================
// state
reg [1:0] sel_ff;
reg [1:0] max_idx_ff;
reg boot_flag_ff;
reg rst_flag_ff;
reg pend_ff;
reg [7:0] pend_data_ff;

function is_boot_addr;
   input [12:0] a;
   begin
      is_boot_addr = (a[12:11] == `SEC_BOOT_LO) ||
         (a[12:11] == `SEC_BOOT_HI);
   end
endfunction

// exact register offset match; shared by the write decodes
function reg_hit;
   input [12:0] a;
   input [12:0] ofs;
   begin
      reg_hit = (a == ofs);
   end
endfunction

// selection gates every register cycle, except a write to the select register
wire id_match = (sel_ff == strap_id);
wire in_reset = (op_mode_ff == `MODE_RESET);
wire wr_sel = bus_wr && reg_hit(bus_addr, `OFS_DEV_SELECT);
wire wr_ctrl = bus_wr && id_match && reg_hit(bus_addr, `OFS_MODE_CTRL);
wire wr_conf = bus_wr && id_match && reg_hit(bus_addr, `OFS_MODE_CONFIRM);
wire wr_cfg = bus_wr && id_match && reg_hit(bus_addr, `OFS_DEV_CONFIG);
// any access other than a boot block read breaks a pending pair
wire other_cyc = (bus_wr || (bus_rd && !is_boot_addr(bus_addr)));
wire pair_ok = wr_conf && pend_ff && (bus_wdata == ~pend_data_ff) &&
   pend_data_ff[`MODE_EN_BIT];
wire [1:0] req_mode = pend_data_ff[`MODE_MSB:`MODE_LSB];
wire mode_legal = (req_mode != 2'h3);
wire hw_reset_entry = ext_rst || volt_trig || boot_trig;
// flag clears ride on a control write outside reset mode
wire clr_boot = wr_ctrl && !in_reset && bus_wdata[`BOOT_FLAG_BIT];
wire clr_rst = wr_ctrl && !in_reset && bus_wdata[`RST_FLAG_BIT];

// ==========================================================
// mode and pending pair
// pair tracker states
localparam PAIR_IDLE = 1'b0;
localparam PAIR_ARMED = 1'b1;

// a reset event outranks a pair that completes in the same cycle
reg [1:0] nxt_mode;
always @* begin
   nxt_mode = op_mode_ff;
   if (hw_reset_entry) begin
      nxt_mode = `MODE_RESET;
   end else if (pair_ok && mode_legal) begin
      nxt_mode = req_mode;
   end
end

// armed by a control write; any access but a boot block read or a control write disarms
// so a stray confirm can never complete a stale pair
reg nxt_pend;
always @* begin
   nxt_pend = pend_ff;
   case (pend_ff)
      PAIR_IDLE: begin
         if (wr_ctrl) begin
            nxt_pend = PAIR_ARMED;
         end
      end
      PAIR_ARMED: begin
         if (wr_ctrl) begin
            nxt_pend = PAIR_ARMED;
         end else if (other_cyc) begin
            nxt_pend = PAIR_IDLE;
         end
      end
      default: begin
         nxt_pend = PAIR_IDLE;
      end
   endcase
end

always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      op_mode_ff <= `MODE_RESET;
      pend_ff <= PAIR_IDLE;
      pend_data_ff <= 8'h00;
   end else begin
      op_mode_ff <= nxt_mode;
      pend_ff <= nxt_pend;
      // a later control write replaces the byte the confirm must match
      if (wr_ctrl) begin
         pend_data_ff <= bus_wdata;
      end
   end
end

// ==========================================================
// sticky reset cause flags; a new event beats the clear
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      boot_flag_ff <= 1'b0;
      rst_flag_ff <= 1'b1;
   end else begin
      if (boot_trig) begin
         boot_flag_ff <= 1'b1;
      end else if (clr_boot) begin
         boot_flag_ff <= 1'b0;
      end
      if (ext_rst || volt_trig) begin
         rst_flag_ff <= 1'b1;
      end else if (clr_rst) begin
         rst_flag_ff <= 1'b0;
      end
   end
end

// ==========================================================
// select and configuration; not touched by reset mode entry
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      sel_ff <= `RST_SELECT;
      max_idx_ff <= `RST_MAX_IDX;
   end else begin
      if (wr_sel) begin
         sel_ff <= bus_wdata[1:0];
      end
      if (wr_cfg && !in_reset) begin
         max_idx_ff <= bus_wdata[`MAX_IDX_MSB:`MAX_IDX_LSB];
      end
   end
end

// ==========================================================
// read path
reg [7:0] rd_val;
always @* begin
   rd_val = 8'h00;
   case (bus_addr)
      `OFS_DEV_SELECT: rd_val = {6'h00, sel_ff};
      `OFS_MODE_CTRL: rd_val = {3'h0, rst_flag_ff, boot_flag_ff, 1'b0,
         op_mode_ff};
      `OFS_DEV_CONFIG: rd_val = {s5b_ff, 1'b0, max_idx_ff, 3'h0, s4b_ff};
      default: rd_val = 8'h00;
   endcase
   if (in_reset || !id_match) begin
      rd_val = 8'h00;
   end
end

// boot block reads answer even when this die is not selected
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      bus_rdata_ff <= 8'h00;
      bus_rvalid_ff <= 1'b0;
   end else begin
      bus_rvalid_ff <= bus_rd && (id_match || is_boot_addr(bus_addr));
      bus_rdata_ff <= bus_rd ? rd_val : 8'h00;
   end
end

// ==========================================================
// status outputs
always @(posedge sys_clk or negedge resetn) begin
   if (!resetn) begin
      chip_selected_ff <= 1'b0;
      boot_block_map_en_ff <= 1'b0;
   end else begin
      chip_selected_ff <= id_match;
      // boot block of this die mapped only if strap within index range
      boot_block_map_en_ff <= (strap_id <= max_idx_ff);
   end
end

endmodule // mode_control_cascade_config

/* mcc_sva.sv */
// ====
// checker
module mcc_sva (
   // clock and reset
   input wire sys_clk,
   input wire resetn,
   // host bus
   input wire [12:0] bus_addr,
   input wire bus_wr,
   input wire bus_rd,
   input wire [7:0] bus_rdata_ff,
   input wire bus_rvalid_ff,
   // events and status
   input wire external_reset_input_n,
   input wire boot_detect_trig,
   input wire voltage_detect_trig,
   input wire [1:0] op_mode_ff,
   input wire chip_selected_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_mode_legal: assert property (op_mode_ff != 2'h3)
      else $error("illegal mode");
   a_enable_zero: assert property (bus_rvalid_ff |-> !bus_rdata_ff[2])
      else $error("enable bit read back");
   a_reset_reads: assert property (
      bus_rvalid_ff && $past(op_mode_ff) == 2'h0 |-> bus_rdata_ff == 8'h00)
      else $error("read in reset mode not zero");
   a_pair_only: assert property (
      $changed(op_mode_ff) && op_mode_ff != 2'h0
      |-> $past(bus_wr) && $past(bus_addr) == 13'h1072)
      else $error("mode moved without confirm");
   a_event_reset: assert property (
      boot_detect_trig || voltage_detect_trig || !external_reset_input_n
      |-> ##[1:4] op_mode_ff == 2'h0) else $error("event kept mode");
   a_answer_cause: assert property (bus_rvalid_ff |-> $past(bus_rd))
      else $error("answer without read");
   a_unselected_quiet: assert property (
      $past(bus_rd) && $past(bus_addr[12:11]) == 2'h2
      && !chip_selected_ff |-> !bus_rvalid_ff)
      else $error("unselected device answered");
   a_reserved_zero: assert property (
      bus_rvalid_ff && $past(bus_addr) == 13'h100C
      |-> bus_rdata_ff[7:5] == 3'h0) else $error("reserved bits set");
endmodule // mcc_sva
bind mode_control_cascade_config mcc_sva chk (.sys_clk(sys_clk),
   .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_rdata_ff(bus_rdata_ff),
   .bus_rvalid_ff(bus_rvalid_ff),
   .external_reset_input_n(external_reset_input_n),
   .boot_detect_trig(boot_detect_trig),
   .voltage_detect_trig(voltage_detect_trig),
   .op_mode_ff(op_mode_ff), .chip_selected_ff(chip_selected_ff));

/* host_model.sv */
// ====
// host bus master
module host_model (
   // clock
   input wire sys_clk,
   // requests
   output logic [12:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      bus_addr = 13'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end
   // request stands until the caller idles or issues the next one
   task automatic op(input logic w, input logic [12:0] a,
         input logic [7:0] d);
      bus_wr = w;
      bus_rd = !w;
      bus_addr = a;
      bus_wdata = d;
      @(posedge sys_clk);
      #1;
   endtask
   // released bus never shows stale values
   task automatic idle();
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = ~bus_addr;
      bus_wdata = ~bus_wdata;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic pair(input logic [7:0] c, input logic [7:0] k);
      op(1'b1, 13'h100C, c);
      op(1'b1, 13'h1072, k);
      idle();
   endtask
endmodule // host_model

/* tb_top.sv */
// ====
// bench
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0;
   logic resetn, bus_wr, bus_rd, bus_rvalid_ff, io_supply_high, if_cfg_strap;
   logic external_reset_input_n, boot_detect_trig, voltage_detect_trig;
   logic chip_selected_ff, boot_block_map_en_ff;
   logic [12:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata_ff, cfg;
   logic [1:0] cascade_id_strap, op_mode_ff;
   logic [7:0] expq[$];
   logic [15:0] tab[5] = '{16'h06F9, 16'h05FA, 16'h0600, 16'h07F8, 16'h02FD};
   logic [31:0] seed = 32'h797C635E;
   int err_total = 0, cmp_count = 0, cyc_n = 0;
   always #5 sys_clk = ~sys_clk;
   host_model host (.sys_clk(sys_clk), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));
   mode_control_cascade_config uut (.sys_clk(sys_clk), .resetn(resetn),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
      .bus_rvalid_ff(bus_rvalid_ff),
      .external_reset_input_n(external_reset_input_n),
      .boot_detect_trig(boot_detect_trig),
      .voltage_detect_trig(voltage_detect_trig),
      .cascade_id_strap(cascade_id_strap),
      .io_supply_high(io_supply_high), .if_cfg_strap(if_cfg_strap),
      .op_mode_ff(op_mode_ff), .chip_selected_ff(chip_selected_ff),
      .boot_block_map_en_ff(boot_block_map_en_ff));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   task rd(input logic [12:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.op(1'b0, a, 8'h00);
      host.idle();
   endtask
   task wr(input logic [12:0] a, input logic [7:0] d);
      host.op(1'b1, a, d);
      host.idle();
   endtask
   task wt();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   function automatic void xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   task close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // mid-cycle, where the registered answer has settled
   always @(negedge sys_clk) begin
      if (bus_rvalid_ff === 1'b1)
         chk(bus_rdata_ff, expq.pop_front());
      cyc_n++;
      if (cyc_n == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      resetn = 1'b0;
      {external_reset_input_n, boot_detect_trig, voltage_detect_trig} = 3'h4;
      cascade_id_strap = 2'h0;
      xs();
      {io_supply_high, if_cfg_strap} = seed[1:0];
      repeat (5) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      wt();
      rd(13'h100C, 8'h00);
      host.pair(8'h05, 8'hFA);
      rd(13'h100C, 8'h11);
      wr(13'h100C, 8'h11);
      rd(13'h100C, 8'h01);
      for (int i = 0; i < 5; i++) begin
         host.pair(tab[i][15:8], tab[i][7:0]);
         chk({6'h00, op_mode_ff}, i == 0 ? 8'h02 : 8'h01);
      end
      $display("mode test done");
      wr(13'h100E, 8'hFF);
      cfg = {if_cfg_strap, 3'h3, 3'h0, io_supply_high};
      rd(13'h100E, cfg);
      expq.push_back(cfg);
      host.op(1'b1, 13'h100C, 8'h06);
      host.op(1'b0, 13'h100E, 8'h00);
      host.op(1'b1, 13'h1072, 8'hF9);
      host.idle();
      chk({6'h00, op_mode_ff}, 8'h01);
      expq.push_back(8'h00);
      host.op(1'b1, 13'h100C, 8'h06);
      host.op(1'b0, 13'h1800, 8'h00);
      host.op(1'b1, 13'h1072, 8'hF9);
      host.idle();
      chk({6'h00, op_mode_ff}, 8'h02);
      host.pair(8'h05, 8'hFA);
      rd(13'h1072, 8'h00);
      for (int i = 0; i < 3; i++) begin
         boot_detect_trig = (i == 0);
         voltage_detect_trig = (i == 1);
         external_reset_input_n = (i != 2);
         @(posedge sys_clk);
         #1;
         {external_reset_input_n, boot_detect_trig, voltage_detect_trig} = 3'h4;
         wt();
         rd(13'h100C, 8'h00);
         host.pair(8'h05, 8'hFA);
         rd(13'h100C, i == 0 ? 8'h09 : 8'h11);
         wr(13'h100C, 8'h19);
      end
      rd(13'h100E, cfg);
      $display("event test done");
      xs();
      cascade_id_strap = seed[1:0];
      wr(13'h100A, {6'h00, seed[1:0] + 2'h1});
      wt();
      chk({7'h00, chip_selected_ff}, 8'h00);
      host.op(1'b0, 13'h100C, 8'h00);
      host.idle();
      host.pair(8'h06, 8'hF9);
      chk({6'h00, op_mode_ff}, 8'h01);
      wr(13'h100A, {6'h3F, seed[1:0]});
      wt();
      chk({7'h00, chip_selected_ff}, 8'h01);
      rd(13'h100C, 8'h01);
      rd(13'h100A, {6'h00, seed[1:0]});
      wr(13'h100E, 8'h00);
      wt();
      chk({7'h00, boot_block_map_en_ff}, {7'h00, seed[1:0] == 2'h0});
      wr(13'h100E, {2'h0, seed[1:0], 4'h0});
      wt();
      chk({7'h00, boot_block_map_en_ff}, 8'h01);
      $display("cascade test done");
      close_out();
   end
endmodule // tb_top
